// ---- sem_device.sv ----
module sem_device #(
  parameter int NUM     = sem_pkg::NUM_SENSORS,
  parameter int DEPTH   = sem_pkg::LOG_DEPTH,
  parameter int WD_CYC  = sem_pkg::WD_DEFAULT_S * sem_pkg::CLK_HZ
) (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic              en_i,
  input  wire logic [2*NUM-1:0]  sensor_i,
  output logic                   online_o,
  output logic [5:0]             log_count_o,
  sem_link_if.dev                link
);
  typedef struct packed {
    logic [31:0]       now;
    logic [15:0]       tick;
    logic [31:0]       wd;
    logic [31:0]       wd_limit;
    logic [31:0]       samp_cyc;
    logic [2*NUM-1:0]  last;
    logic [NUM-1:0]    used;
    logic              online;
    logic [5:0]        wr;
    logic [5:0]        rd;
    logic [6:0]        cnt;
    logic              draining;
    logic [5:0]        snap;
    logic              snapping;
    logic              ev_valid;
    logic [1:0]        ev_kind;
    logic [31:0]       ev_time;
    logic [4:0]        ev_sensor;
    logic [1:0]        ev_status;
  } sem_dev_type;
  sem_dev_type r, next_r;
  logic [38:0] logmem [DEPTH];
  logic        log_we;
  logic [38:0] log_wdata;
  logic [4:0]  chg_idx;
  logic        chg_found;
  logic        cmd_ok;
  // Lowest-numbered change wins; others are caught on later samples.
  always_comb begin
    chg_found = 1'b0;
    chg_idx = 5'h00;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (r.used[i] && sensor_i[2*i +: 2] != r.last[2*i +: 2]) begin
        chg_found = 1'b1;
        chg_idx = 5'(i);
      end
    end
  end
  assign cmd_ok = link.cmd_valid && link.cmd_node == 4'(sem_pkg::MASTER_NODE);
  always_comb begin
    next_r = r;
    log_we = 1'b0;
    log_wdata = '0;
    next_r.ev_valid = 1'b0;
    next_r.now = r.now + 32'h1;
    next_r.wd = (r.wd == 32'h0) ? 32'h0 : r.wd - 32'h1;
    if (r.online && r.wd == 32'h1) begin
      next_r.online = 1'b0;
    end
    if (cmd_ok) begin
      unique case (link.cmd)
        sem_pkg::CMD_CONFIG: begin
          next_r.used = link.cmd_used[NUM-1:0];
          next_r.samp_cyc = link.cmd_data;
        end
        sem_pkg::CMD_SET_TIME: next_r.now = link.cmd_data;
        sem_pkg::CMD_READ_LOG: next_r.draining = 1'b1;
        sem_pkg::CMD_SNAPSHOT: begin
          next_r.snapping = 1'b1;
          next_r.snap = 6'h00;
        end
        sem_pkg::CMD_KEEPALIVE: begin
          if (link.cmd_data != 32'h0) begin
            next_r.wd_limit = link.cmd_data;
          end
          if (r.online) begin
            next_r.wd = (link.cmd_data != 32'h0) ? link.cmd_data : r.wd_limit;
          end
        end
        default: ;
      endcase
    end
    next_r.tick = (r.tick >= r.samp_cyc[15:0] - 16'h1) ? 16'h0 : r.tick + 16'h1;
    if (r.tick == 16'h0 && chg_found) begin
      next_r.last[2*chg_idx +: 2] = sensor_i[2*chg_idx +: 2];
      if (r.online) begin
        next_r.ev_valid = 1'b1;
        next_r.ev_kind = sem_pkg::EVK_ONLINE;
        next_r.ev_time = r.now;
        next_r.ev_sensor = chg_idx + 5'h1;
        next_r.ev_status = sensor_i[2*chg_idx +: 2];
      end else if (r.cnt < 7'(DEPTH)) begin
        log_we = 1'b1;
        log_wdata = {r.now, chg_idx + 5'h1, sensor_i[2*chg_idx +: 2]};
        next_r.wr = r.wr + 6'h1;
        next_r.cnt = r.cnt + 7'h1;
      end
    end else if (r.draining) begin
      next_r.ev_valid = 1'b1;
      if (r.cnt == 7'h0) begin
        next_r.ev_kind = sem_pkg::EVK_LOG_END;
        next_r.draining = 1'b0;
      end else begin
        next_r.ev_kind = sem_pkg::EVK_OFFLINE;
        {next_r.ev_time, next_r.ev_sensor, next_r.ev_status} = logmem[r.rd];
        next_r.rd = r.rd + 6'h1;
        next_r.cnt = r.cnt - 7'h1;
      end
    end else if (r.snapping) begin
      next_r.ev_valid = 1'b1;
      next_r.ev_kind = sem_pkg::EVK_STATUS;
      next_r.ev_time = r.now;
      next_r.ev_sensor = r.snap[4:0] + 5'h1;
      next_r.ev_status = sensor_i[2*r.snap[4:0] +: 2];
      next_r.last[2*r.snap[4:0] +: 2] = sensor_i[2*r.snap[4:0] +: 2];
      next_r.snap = r.snap + 6'h1;
      if (r.snap == 6'(NUM - 1)) begin
        next_r.snapping = 1'b0;
        next_r.online = 1'b1;
        next_r.wd = r.wd_limit;
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.samp_cyc <= 32'(sem_pkg::SAMPLE_DEFAULT_CYC);
      r.wd_limit <= 32'(WD_CYC);
      r.used <= '1;
    end else if (en_i) begin
      r <= next_r;
    end
  end
  // Log memory has no reset; entries are only read below the fill count.
  always_ff @(posedge clk_sys_i) begin
    if (en_i && log_we) begin
      logmem[r.wr] <= log_wdata;
    end
  end
  assign link.ev_valid = r.ev_valid;
  assign link.ev_kind = r.ev_kind;
  assign link.ev_time = r.ev_time;
  assign link.ev_sensor = r.ev_sensor;
  assign link.ev_status = r.ev_status;
  assign online_o = r.online;
  assign log_count_o = r.cnt[5:0];
endmodule

// ---- sem_pkg.sv ----
package sem_pkg;
  localparam int NUM_SENSORS = 20;
  localparam int TS_W = 32;
  localparam int SNUM_W = 5;
  localparam int LOG_DEPTH = 64;
  localparam int CLK_HZ = 125000000;
  localparam int WD_DEFAULT_S = 5;
  localparam int SAMPLE_DEFAULT_CYC = 1000;
  localparam int MASTER_NODE = 1;
  localparam logic [1:0] ST_OPEN = 2'h0;
  localparam logic [1:0] ST_CLOSED = 2'h1;
  localparam logic [1:0] ST_BROKEN = 2'h2;
  localparam logic [1:0] ST_SHORT = 2'h3;
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_CONFIG = 3'h1;
  localparam logic [2:0] CMD_SET_TIME = 3'h2;
  localparam logic [2:0] CMD_READ_LOG = 3'h3;
  localparam logic [2:0] CMD_SNAPSHOT = 3'h4;
  localparam logic [2:0] CMD_KEEPALIVE = 3'h5;
  localparam logic [1:0] EVK_ONLINE = 2'h0;
  localparam logic [1:0] EVK_OFFLINE = 2'h1;
  localparam logic [1:0] EVK_STATUS = 2'h2;
  localparam logic [1:0] EVK_LOG_END = 2'h3;
endpackage

// ---- sem_link_if.sv ----
interface sem_link_if;
  logic                      cmd_valid;
  logic [2:0]                cmd;
  logic [3:0]                cmd_node;
  logic [31:0]               cmd_data;
  logic [19:0]               cmd_used;
  logic                      ev_valid;
  logic [1:0]                ev_kind;
  logic [sem_pkg::TS_W-1:0]  ev_time;
  logic [4:0]                ev_sensor;
  logic [1:0]                ev_status;
  modport dev (input cmd_valid, cmd, cmd_node, cmd_data, cmd_used,
               output ev_valid, ev_kind, ev_time, ev_sensor, ev_status);
  modport host (output cmd_valid, cmd, cmd_node, cmd_data, cmd_used,
                input ev_valid, ev_kind, ev_time, ev_sensor, ev_status);
endinterface

// ---- sem_host.sv ----
module sem_host #(
  parameter int KA_CYC = sem_pkg::CLK_HZ
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic         en_i,
  input  wire logic         start_i,
  input  wire logic [19:0]  cfg_used_i,
  input  wire logic [31:0]  cfg_sample_i,
  input  wire logic [31:0]  time_i,
  output logic              ev_valid_o,
  output logic              ev_offline_o,
  output logic [31:0]       ev_time_o,
  output logic [4:0]        ev_sensor_o,
  output logic [1:0]        ev_status_o,
  output logic              ready_o,
  sem_link_if.host          link
);
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_CFG = 6'h02, S_TIME = 6'h04,
    S_DRAIN = 6'h08, S_SNAP = 6'h10, S_RUN = 6'h20
  } sem_hst_state_type;
  typedef struct packed {
    sem_hst_state_type st;
    logic [31:0]       ka;
    logic [4:0]        snaps;
    logic              cmd_valid;
    logic [2:0]        cmd;
    logic [31:0]       cmd_data;
    logic              ev_valid;
    logic              ev_offline;
    logic [31:0]       ev_time;
    logic [4:0]        ev_sensor;
    logic [1:0]        ev_status;
    logic              ready;
  } sem_hst_type;
  sem_hst_type r, next_r;
  function automatic logic is_ev(input logic [1:0] k);
    return k == sem_pkg::EVK_ONLINE || k == sem_pkg::EVK_OFFLINE;
  endfunction
  always_comb begin
    next_r = r;
    next_r.cmd_valid = 1'b0;
    next_r.cmd = sem_pkg::CMD_NONE;
    next_r.ev_valid = link.ev_valid && is_ev(link.ev_kind);
    next_r.ev_offline = link.ev_kind == sem_pkg::EVK_OFFLINE;
    next_r.ev_time = link.ev_time;
    next_r.ev_sensor = link.ev_sensor;
    next_r.ev_status = link.ev_status;
    unique case (r.st)
      S_IDLE: if (start_i) begin
        next_r.st = S_CFG;
      end
      S_CFG: begin
        next_r.cmd_valid = 1'b1;
        next_r.cmd = sem_pkg::CMD_CONFIG;
        next_r.cmd_data = cfg_sample_i;
        next_r.st = S_TIME;
      end
      S_TIME: begin
        next_r.cmd_valid = 1'b1;
        next_r.cmd = sem_pkg::CMD_SET_TIME;
        next_r.cmd_data = time_i;
        next_r.st = S_DRAIN;
      end
      S_DRAIN: begin
        // Issued only in the entry cycle, so the log is drained exactly once.
        if (r.cmd_valid && r.cmd == sem_pkg::CMD_SET_TIME) begin
          next_r.cmd_valid = 1'b1;
          next_r.cmd = sem_pkg::CMD_READ_LOG;
        end
        if (link.ev_valid && link.ev_kind == sem_pkg::EVK_LOG_END) begin
          next_r.cmd_valid = 1'b1;
          next_r.cmd = sem_pkg::CMD_SNAPSHOT;
          next_r.snaps = 5'h0;
          next_r.st = S_SNAP;
        end
      end
      S_SNAP: if (link.ev_valid && link.ev_kind == sem_pkg::EVK_STATUS) begin
        next_r.snaps = r.snaps + 5'h1;
        if (r.snaps == 5'(sem_pkg::NUM_SENSORS - 1)) begin
          next_r.st = S_RUN;
          next_r.ready = 1'b1;
          next_r.ka = 32'h0;
        end
      end
      S_RUN: begin
        next_r.ka = r.ka + 32'h1;
        if (r.ka >= 32'(KA_CYC)) begin
          next_r.ka = 32'h0;
          next_r.cmd_valid = 1'b1;
          next_r.cmd = sem_pkg::CMD_KEEPALIVE;
          next_r.cmd_data = 32'h0;
        end
        if (!start_i) begin
          next_r.st = S_IDLE;
          next_r.ready = 1'b0;
        end
      end
      default: next_r.st = S_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.st <= S_IDLE;
    end else if (en_i) begin
      r <= next_r;
    end
  end
  assign link.cmd_valid = r.cmd_valid;
  assign link.cmd = r.cmd;
  assign link.cmd_node = 4'(sem_pkg::MASTER_NODE);
  assign link.cmd_data = r.cmd_data;
  assign link.cmd_used = cfg_used_i;
  assign ev_valid_o = r.ev_valid;
  assign ev_offline_o = r.ev_offline;
  assign ev_time_o = r.ev_time;
  assign ev_sensor_o = r.ev_sensor;
  assign ev_status_o = r.ev_status;
  assign ready_o = r.ready;
endmodule

// ---- sem_monitor.sv ----
module sem_monitor (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd,
  input  wire logic [3:0]  cmd_node,
  input  wire logic [31:0] cmd_data,
  input  wire logic [19:0] cmd_used,
  input  wire logic        ev_valid,
  input  wire logic [1:0]  ev_kind,
  input  wire logic [31:0] ev_time,
  input  wire logic [4:0]  ev_sensor,
  input  wire logic [1:0]  ev_status
);
  logic [2:0] last;
  logic       ka;
  logic       st;
  assign ka = cmd_valid && cmd == sem_pkg::CMD_KEEPALIVE;
  assign st = ev_valid && ev_kind == sem_pkg::EVK_STATUS;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) last <= sem_pkg::CMD_NONE;
    else if (cmd_valid) last <= cmd;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_node_master: assert property (
    cmd_valid |-> cmd_node == 4'h1) else $error("command sent to wrong node");
  a_config_first: assert property (
    cmd_valid && last == sem_pkg::CMD_NONE |-> cmd == sem_pkg::CMD_CONFIG)
    else $error("first command is not config");
  a_time_after_cfg: assert property (
    cmd_valid && cmd == sem_pkg::CMD_SET_TIME |-> last == sem_pkg::CMD_CONFIG)
    else $error("time set out of order");
  a_log_after_time: assert property (
    cmd_valid && cmd == sem_pkg::CMD_READ_LOG |-> last == sem_pkg::CMD_SET_TIME)
    else $error("log read out of order");
  a_snap_after_log: assert property (
    cmd_valid && cmd == sem_pkg::CMD_SNAPSHOT |-> last == sem_pkg::CMD_READ_LOG)
    else $error("snapshot before log read");
  a_log_end_bound: assert property (
    cmd_valid && cmd == sem_pkg::CMD_READ_LOG
    |-> ##[1:80] (ev_valid && ev_kind == sem_pkg::EVK_LOG_END))
    else $error("log drain did not end");
  a_snap_starts: assert property (
    cmd_valid && cmd == sem_pkg::CMD_SNAPSHOT |-> ##[1:3] st)
    else $error("snapshot gave no status");
  a_snap_walks: assert property (
    st && ev_sensor < 5'h14 |=> (st && ev_sensor == $past(ev_sensor) + 5'h01)
    or (!ev_valid ##1 (st && ev_sensor == $past(ev_sensor, 2) + 5'h01)))
    else $error("snapshot skipped a sensor");
  a_sensor_range: assert property (
    ev_valid && ev_kind != sem_pkg::EVK_LOG_END |-> ev_sensor inside {[5'h01:5'h14]})
    else $error("event sensor number out of range");
  a_ka_spacing: assert property (
    ka |=> !ka [*8]) else $error("keepalives too close");
endmodule

// ---- sensor_event_monitor_bench.sv ----
module sensor_event_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i, nrst_i, en_host, start;
  logic [39:0] sensor;
  logic [31:0] time_i;
  logic        h_valid, h_off, ready, online;
  logic [31:0] h_time;
  logic [4:0]  h_sensor;
  logic [1:0]  h_status;
  logic [5:0]  log_count;
  logic [7:0]  q[$];
  int          n_errors, tests_run, i, n;
  sem_link_if link ();
  sem_device #(.WD_CYC(200)) sem_device_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .en_i(1'b1), .sensor_i(sensor), .online_o(online), .log_count_o(log_count), .link(link));
  sem_host #(.KA_CYC(50)) sem_host_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .en_i(en_host), .start_i(start), .cfg_used_i(20'h7FFFF), .cfg_sample_i(32'h00000014),
    .time_i(time_i), .ev_valid_o(h_valid), .ev_offline_o(h_off), .ev_time_o(h_time),
    .ev_sensor_o(h_sensor), .ev_status_o(h_status), .ready_o(ready), .link(link));
  sem_monitor sem_monitor_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .cmd_valid(link.cmd_valid), .cmd(link.cmd), .cmd_node(link.cmd_node),
    .cmd_data(link.cmd_data), .cmd_used(link.cmd_used), .ev_valid(link.ev_valid),
    .ev_kind(link.ev_kind), .ev_time(link.ev_time), .ev_sensor(link.ev_sensor),
    .ev_status(link.ev_status));
  task automatic finish_test();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A wait that runs out ends the run at once, since later steps assume the state.
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) @(posedge clk_sys_i);
    if (s !== v) begin
      n_errors++;
      finish_test();
    end
  endtask
  // XOR with 1..3 guarantees the sensor really changes.
  task automatic chg(input int k, input logic off, input logic push);
    logic [1:0] s;
    s = sensor[2*k+:2] ^ (2'h1 + 2'($urandom % 3));
    @(posedge clk_sys_i);
    sensor[2*k+:2] <= s;
    if (push) q.push_back({off, 5'(k + 1), s});
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Snapshot events are skipped: only offline entries and online changes are noted.
  always @(posedge clk_sys_i) begin
    if (h_valid && (h_off || ready)) begin
      if (q.size() == 0) check(8'h00, 8'hFF);
      else check({h_off, h_sensor, h_status}, q.pop_front());
    end
  end
  initial begin
    nrst_i = 1'b0;
    en_host = 1'b1;
    start = 1'b0;
    sensor = 40'h0;
    time_i = 32'h0;
    void'($urandom(33));
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    time_i <= $urandom;
    for (i = 0; i < 3; i++) begin
      chg($urandom % 19, 1'b1, 1'b1);
      repeat (1100) @(posedge clk_sys_i);
    end
    check({2'h0, log_count}, 8'h03);
    start <= 1'b1;
    wait_lvl(ready, 1'b1, 3000);
    check({7'h0, online}, 8'h01);
    for (i = 0; i < 5; i++) begin
      chg($urandom % 19, 1'b0, 1'b1);
      repeat (40) @(posedge clk_sys_i);
    end
    chg(19, 1'b0, 1'b0);
    repeat (300) @(posedge clk_sys_i);
    check({7'h0, online}, 8'h01);
    // Freeze the host just after a keepalive, so no command pulse is held high.
    for (int k = 0; k < 60 && link.cmd_valid !== 1'b1; k++) @(posedge clk_sys_i);
    en_host <= 1'b0;
    wait_lvl(online, 1'b0, 400);
    n = log_count;
    chg($urandom % 19, 1'b1, 1'b1);
    repeat (40) @(posedge clk_sys_i);
    check({2'h0, log_count}, 8'(n + 1));
    en_host <= 1'b1;
    start <= 1'b0;
    @(posedge clk_sys_i);
    start <= 1'b1;
    wait_lvl(online, 1'b1, 3000);
    repeat (20) @(posedge clk_sys_i);
    check(8'(q.size()), 8'h00);
    finish_test();
  end
endmodule
